/* File: src/lsr_defines.svh */
// Offsets, field positions, reset values and timing counts of the loop status bank.
// Assumes an APB master with 32-bit data; each register index is one aligned word.
`ifndef LSR_DEFINES_SVH
`define LSR_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define LSR_IDX_REF_STATE    10'h082
`define LSR_IDX_DAC_AVG      10'h083
`define LSR_IDX_DAC_CUR      10'h084
`define LSR_IDX_REF_FLAGS    10'h085
`define LSR_IDX_EXIT_INFO    10'h086
`define LSR_IDX_RSVD_A       10'h087
`define LSR_IDX_IRQ_STATUS   10'h088
`define LSR_IDX_IRQ_MASK     10'h089
`define LSR_IDX_CAP_BANK     10'h08C
`define LSR_IDX_ERR_LOW      10'h08D
`define LSR_IDX_ERR_HIGH     10'h08E
`define LSR_IDX_TUNE_SYNC    10'h08F
`define LSR_IDX_RSVD_B       10'h090

// Field positions.
`define LSR_POS_PREFERRED    5
`define LSR_POS_ACTIVE       3
`define LSR_POS_CMP          7
`define LSR_POS_ACTIVE_LOS   3
`define LSR_POS_REF_FAST     2
`define LSR_POS_ADC_FAST     1
`define LSR_POS_ADC_OOR      0
`define LSR_POS_EXIT_PHASE   3
`define LSR_POS_BUSY         7
`define LSR_POS_SIGN         6
`define LSR_POS_TUNE_STATE   4

// Interrupt event bits.
`define LSR_EV_ACTIVE_LOS    0
`define LSR_EV_TUNE_DONE     1
`define LSR_EV_HOLDOVER      2
`define LSR_EV_LOCKED        3
`define LSR_EV_ADC_OOR       4
`define LSR_EV_WIDTH         5

// Reset values.
`define LSR_RST_BYTE         8'h00
`define LSR_RST_WORD         32'h0000_0000
`define LSR_RST_EVENTS       5'h00

// Timing counts in clock cycles.
`define LSR_READ_LATENCY     1

`endif

/* File: src/lsr_pkg.sv */
// Types shared by the loop status bank and its environment.
// Assumes the loop state machines deliver their status on the bank's own clock.
package lsr_pkg;

    typedef enum logic [2:0] {
        REF_RESET = 3'b000, REF_ACQUIRE = 3'b001, REF_LOCKED = 3'b010,
        REF_INVALID = 3'b011, REF_HOLDOVER = 3'b100, REF_DAC_EXIT = 3'b101
    } lsr_ref_state_t;

    typedef enum logic [3:0] {
        TUNE_IDLE = 4'h0, TUNE_START_A = 4'h1, TUNE_START_B = 4'h2,
        TUNE_RESET_A = 4'h3, TUNE_RESET_B = 4'h4, TUNE_RESET_C = 4'h5,
        TUNE_MEASURE = 4'h6, TUNE_WAIT_A = 4'h7, TUNE_WAIT_B = 4'h8,
        TUNE_UPDATE = 4'h9, TUNE_ROUND = 4'hA, TUNE_FINISH = 4'hB
    } lsr_tune_state_t;

    typedef enum logic [3:0] {
        SYNC_IDLE = 4'h0, SYNC_UP_A = 4'h4, SYNC_UP_B = 4'h6,
        SYNC_SEND = 4'h7, SYNC_DOWN_A = 4'hE, SYNC_DOWN_B = 4'hC
    } lsr_sync_state_t;

    typedef enum logic [1:0] {
        APB_IDLE = 2'b01, APB_ACCESS = 2'b10
    } lsr_apb_state_t;

    typedef struct packed {
        logic [1:0]     preferred;
        logic [1:0]     active;
        lsr_ref_state_t state;
        logic [6:0]     dac_avg;
        logic           cmp;
        logic [6:0]     dac_cur;
        logic           active_los;
        logic           ref_fast;
        logic           adc_fast;
        logic           adc_oor;
        logic [1:0]     exit_phase;
    } lsr_ref_stat_t;

    typedef struct packed {
        logic            busy;
        logic [7:0]      bank;
        logic            err_neg;
        logic [13:0]     err_mag;
        lsr_tune_state_t tune_state;
        lsr_sync_state_t sync_state;
    } lsr_syn_stat_t;

endpackage

/* File: src/lsr_loop_status.sv */
// Read-only status bank of the reference and synthesis loops, with an event interrupt.
// Assumes the status inputs come from logic on CLK_I and an APB master on the same clock.
//
// Overview of operation
// - Reference loop state in three-bit field.
// - Report preferred reference under automatic switching.
// - Report index of reference currently used.
// - Averaged and current DAC codes, comparator bit.
// - Flag loss of signal on active reference.
// - Flag any reference faster than crystal.
// - Holdover ADC acquiring or tuning moving fast.
// - Holdover ADC tuning voltage range flag.
// - Report holdover exit sequence phase.
// - Load capacitor bank at done; busy flag.
// - Fourteen-bit tuning error split, with sign.
// - Autotune state in four-bit field.
// - Divider sync state in four-bit field.
`timescale 1ns/10ps
`include "lsr_defines.svh"

module lsr_loop_status
    import lsr_pkg::*;
(
    // Clock and reset.
    input  wire logic          CLK_I,
    input  wire logic          RST_B_I,
    // APB slave.
    input  wire logic          PSEL_I,
    input  wire logic          PENABLE_I,
    input  wire logic          PWRITE_I,
    input  wire logic [11:0]   PADDR_I,
    input  wire logic [31:0]   PWDATA_I,
    output logic      [31:0]   PRDATA_O,
    output logic               PREADY_O,
    output logic               PSLVERR_O,
    // Loop status.
    input  wire lsr_ref_stat_t REF_STAT_I,
    input  wire lsr_syn_stat_t SYN_STAT_I,
    // Interrupt.
    output logic               IRQ_O
);

    lsr_apb_state_t          apb_q;
    lsr_apb_state_t          apb_d;
    lsr_ref_stat_t           ref_q;
    lsr_syn_stat_t           syn_q;
    logic [7:0]              bank_q;
    logic [`LSR_EV_WIDTH-1:0] sts_q;
    logic [`LSR_EV_WIDTH-1:0] sts_d;
    logic [`LSR_EV_WIDTH-1:0] mask_q;
    logic [`LSR_EV_WIDTH-1:0] events;
    logic [`LSR_EV_WIDTH-1:0] clr;
    logic [31:0]             rdata_d;
    logic [31:0]             rdata_q;
    logic                    err_d;
    logic                    err_q;
    logic                    ready_q;
    logic                    irq_q;
    logic [7:0]              r_state;
    logic [7:0]              r_dac_avg;
    logic [7:0]              r_dac_cur;
    logic [7:0]              r_flags;
    logic [7:0]              r_exit;
    logic [7:0]              r_err_low;
    logic [7:0]              r_err_high;
    logic [7:0]              r_tune_sync;
    logic [9:0]              idx;
    logic                    setup;
    logic                    done;
    logic                    wr_done;

    function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
        hit = (a == r);
    endfunction

    assign idx     = PADDR_I[11:2];
    assign setup   = PSEL_I & ~PENABLE_I;
    assign done    = (apb_q == APB_ACCESS) & PSEL_I & PENABLE_I & ready_q;
    assign wr_done = done & PWRITE_I;

    // Register images; reserved bits are tied low here so no read can leak state.
    assign r_state     = {1'b0, ref_q.preferred, ref_q.active, ref_q.state};
    assign r_dac_avg   = {1'b0, ref_q.dac_avg};
    assign r_dac_cur   = {ref_q.cmp, ref_q.dac_cur};
    assign r_flags     = {4'h0, ref_q.active_los, ref_q.ref_fast,
                          ref_q.adc_fast, ref_q.adc_oor};
    assign r_exit      = {3'b000, ref_q.exit_phase, 3'b000};
    assign r_err_low   = syn_q.err_mag[7:0];
    assign r_err_high  = {syn_q.busy, syn_q.err_neg, syn_q.err_mag[13:8]};
    assign r_tune_sync = {syn_q.tune_state, syn_q.sync_state};

    // Read data is chosen during setup so the access phase never waits.
    always_comb begin
        rdata_d = `LSR_RST_WORD;
        err_d   = 1'b0;
        if (hit(idx, `LSR_IDX_REF_STATE)) begin
            rdata_d = {24'h000000, r_state};
        end else if (hit(idx, `LSR_IDX_DAC_AVG)) begin
            rdata_d = {24'h000000, r_dac_avg};
        end else if (hit(idx, `LSR_IDX_DAC_CUR)) begin
            rdata_d = {24'h000000, r_dac_cur};
        end else if (hit(idx, `LSR_IDX_REF_FLAGS)) begin
            rdata_d = {24'h000000, r_flags};
        end else if (hit(idx, `LSR_IDX_EXIT_INFO)) begin
            rdata_d = {24'h000000, r_exit};
        end else if (hit(idx, `LSR_IDX_RSVD_A) || hit(idx, `LSR_IDX_RSVD_B)) begin
            rdata_d = `LSR_RST_WORD;
        end else if (hit(idx, `LSR_IDX_IRQ_STATUS)) begin
            rdata_d = {27'h0000000, sts_q};
        end else if (hit(idx, `LSR_IDX_IRQ_MASK)) begin
            rdata_d = {27'h0000000, mask_q};
        end else if (hit(idx, `LSR_IDX_CAP_BANK)) begin
            rdata_d = {24'h000000, bank_q};
        end else if (hit(idx, `LSR_IDX_ERR_LOW)) begin
            rdata_d = {24'h000000, r_err_low};
        end else if (hit(idx, `LSR_IDX_ERR_HIGH)) begin
            rdata_d = {24'h000000, r_err_high};
        end else if (hit(idx, `LSR_IDX_TUNE_SYNC)) begin
            rdata_d = {24'h000000, r_tune_sync};
        end else begin
            err_d = 1'b1;
        end
    end

    always_comb begin
        apb_d = apb_q;
        case (apb_q)
            APB_IDLE: begin
                if (setup) begin
                    apb_d = APB_ACCESS;
                end
            end
            APB_ACCESS: begin
                if (done) begin
                    apb_d = APB_IDLE;
                end
            end
            default: begin
                apb_d = APB_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            apb_q   <= APB_IDLE;
            ready_q <= 1'b0;
            rdata_q <= `LSR_RST_WORD;
            err_q   <= 1'b0;
        end else begin
            apb_q   <= apb_d;
            ready_q <= setup;
            rdata_q <= setup ? rdata_d : `LSR_RST_WORD;
            err_q   <= setup & err_d;
        end
    end

    // Status snapshot; the capacitor bank only moves when an autotune finishes.
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            ref_q  <= '0;
            syn_q  <= '0;
            bank_q <= `LSR_RST_BYTE;
        end else begin
            ref_q  <= REF_STAT_I;
            syn_q  <= SYN_STAT_I;
            if (syn_q.busy && !SYN_STAT_I.busy) begin
                bank_q <= SYN_STAT_I.bank;
            end
        end
    end

    // Events are edges seen against the snapshot; a set in the clearing cycle wins.
    assign events[`LSR_EV_ACTIVE_LOS] = REF_STAT_I.active_los & ~ref_q.active_los;
    assign events[`LSR_EV_TUNE_DONE]  = syn_q.busy & ~SYN_STAT_I.busy;
    assign events[`LSR_EV_HOLDOVER]   = (REF_STAT_I.state == REF_HOLDOVER) &
                                        (ref_q.state != REF_HOLDOVER);
    assign events[`LSR_EV_LOCKED]     = (REF_STAT_I.state == REF_LOCKED) &
                                        (ref_q.state != REF_LOCKED);
    assign events[`LSR_EV_ADC_OOR]    = REF_STAT_I.adc_oor & ~ref_q.adc_oor;
    assign clr   = (wr_done && hit(idx, `LSR_IDX_IRQ_STATUS)) ?
                   PWDATA_I[`LSR_EV_WIDTH-1:0] : `LSR_RST_EVENTS;
    assign sts_d = (sts_q & ~clr) | events;

    // Only the interrupt registers accept writes; every status register ignores them.
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            sts_q  <= `LSR_RST_EVENTS;
            mask_q <= `LSR_RST_EVENTS;
            irq_q  <= 1'b0;
        end else begin
            sts_q <= sts_d;
            irq_q <= |(sts_d & (wr_done && hit(idx, `LSR_IDX_IRQ_MASK) ?
                     PWDATA_I[`LSR_EV_WIDTH-1:0] : mask_q));
            if (wr_done && hit(idx, `LSR_IDX_IRQ_MASK)) begin
                mask_q <= PWDATA_I[`LSR_EV_WIDTH-1:0];
            end
        end
    end

    assign PRDATA_O  = rdata_q;
    assign PREADY_O  = ready_q;
    assign PSLVERR_O = err_q;
    assign IRQ_O     = irq_q;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    logic rd_setup;
    assign rd_setup = setup & ~PWRITE_I;

    property p_state_read;
        rd_setup && hit(idx, `LSR_IDX_REF_STATE) |=>
            PRDATA_O[2:0] == $past(ref_q.state) && PRDATA_O[7] == 1'b0;
    endproperty
    a_state_read: assert property (p_state_read) else $error("state field wrong");

    property p_preferred;
        rd_setup && hit(idx, `LSR_IDX_REF_STATE) |=>
            PRDATA_O[6:5] == $past(REF_STAT_I.preferred, 2);
    endproperty
    a_preferred: assert property (p_preferred) else $error("preferred field wrong");

    property p_active;
        rd_setup && hit(idx, `LSR_IDX_REF_STATE) |=> PRDATA_O[4:3] == $past(REF_STAT_I.active, 2);
    endproperty
    a_active: assert property (p_active) else $error("active field wrong");

    property p_dac_cur;
        rd_setup && hit(idx, `LSR_IDX_DAC_CUR) |=>
            PRDATA_O[7:0] == {$past(ref_q.cmp), $past(ref_q.dac_cur)};
    endproperty
    a_dac_cur: assert property (p_dac_cur) else $error("current DAC code wrong");

    property p_flags;
        rd_setup && hit(idx, `LSR_IDX_REF_FLAGS) |=>
            PRDATA_O[3:0] == $past({REF_STAT_I.active_los, REF_STAT_I.ref_fast,
                                    REF_STAT_I.adc_fast, REF_STAT_I.adc_oor}, 2);
    endproperty
    a_flags: assert property (p_flags) else $error("monitor flags wrong");

    property p_exit;
        rd_setup && hit(idx, `LSR_IDX_EXIT_INFO) |=>
            PRDATA_O[4:3] == $past(ref_q.exit_phase) && PRDATA_O[2:0] == 3'b000;
    endproperty
    a_exit: assert property (p_exit) else $error("exit phase wrong");

    property p_bank_load;
        syn_q.busy && !SYN_STAT_I.busy |=> bank_q == $past(SYN_STAT_I.bank);
    endproperty
    a_bank_load: assert property (p_bank_load) else $error("bank not loaded");

    property p_bank_hold;
        SYN_STAT_I.busy ##1 SYN_STAT_I.busy |-> $stable(bank_q);
    endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("bank moved during tune");

    property p_err_high;
        rd_setup && hit(idx, `LSR_IDX_ERR_HIGH) |=>
            PRDATA_O[7:0] == {$past(syn_q.busy), $past(syn_q.err_neg),
                              $past(syn_q.err_mag[13:8])};
    endproperty
    a_err_high: assert property (p_err_high) else $error("error high wrong");

    property p_tune_sync;
        rd_setup && hit(idx, `LSR_IDX_TUNE_SYNC) |=>
            PRDATA_O[7:4] == $past(SYN_STAT_I.tune_state, 2)
            && PRDATA_O[3:0] == $past(SYN_STAT_I.sync_state, 2);
    endproperty
    a_tune_sync: assert property (p_tune_sync) else $error("tune sync wrong");

    property p_reserved;
        rd_setup && (hit(idx, `LSR_IDX_RSVD_A) || hit(idx, `LSR_IDX_RSVD_B)) |=>
            PREADY_O && PRDATA_O == 32'h0000_0000 && !PSLVERR_O;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved read nonzero");

    property p_no_write;
        wr_done && !hit(idx, `LSR_IDX_IRQ_MASK) |=> $stable(mask_q);
    endproperty
    a_no_write: assert property (p_no_write) else $error("status write reached a register");

    property p_irq;
        ##1 IRQ_O == |(sts_q & mask_q);
    endproperty
    a_irq: assert property (p_irq) else $error("irq level wrong");

    property p_dac_avg;
        rd_setup && hit(idx, `LSR_IDX_DAC_AVG) |=>
            PRDATA_O[7:0] == {1'b0, $past(REF_STAT_I.dac_avg, 2)};
    endproperty
    a_dac_avg: assert property (p_dac_avg) else $error("averaged DAC code wrong");

    property p_ref_fast;
        rd_setup && hit(idx, `LSR_IDX_REF_FLAGS) |=>
            PRDATA_O[2] == $past(REF_STAT_I.ref_fast, 2) && PRDATA_O[7:4] == 4'h0;
    endproperty
    a_ref_fast: assert property (p_ref_fast) else $error("fast reference flag wrong");

    property p_adc_fast;
        rd_setup && hit(idx, `LSR_IDX_REF_FLAGS) |=>
            PRDATA_O[1] == $past(REF_STAT_I.adc_fast, 2);
    endproperty
    a_adc_fast: assert property (p_adc_fast) else $error("ADC activity flag wrong");

    property p_adc_oor;
        rd_setup && hit(idx, `LSR_IDX_REF_FLAGS) |=>
            PRDATA_O[0] == $past(REF_STAT_I.adc_oor, 2);
    endproperty
    a_adc_oor: assert property (p_adc_oor) else $error("ADC range flag wrong");

    property p_err_low;
        rd_setup && hit(idx, `LSR_IDX_ERR_LOW) |=>
            PRDATA_O == {24'h000000, $past(SYN_STAT_I.err_mag[7:0], 2)};
    endproperty
    a_err_low: assert property (p_err_low) else $error("error low wrong");

    property p_bank_read;
        rd_setup && hit(idx, `LSR_IDX_CAP_BANK) |=>
            PRDATA_O == {24'h000000, $past(bank_q)};
    endproperty
    a_bank_read: assert property (p_bank_read) else $error("bank read wrong");

    property p_sync_state;
        rd_setup && hit(idx, `LSR_IDX_TUNE_SYNC) |=>
            PRDATA_O[3:0] == $past(SYN_STAT_I.sync_state, 2);
    endproperty
    a_sync_state: assert property (p_sync_state) else $error("sync state wrong");

    property p_upper_zero;
        PREADY_O |-> PRDATA_O[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

    property p_ready_answer;
        setup |=> PREADY_O;
    endproperty
    a_ready_answer: assert property (p_ready_answer) else $error("no ready after setup");

    property p_ready_pulse;
        PREADY_O |=> !PREADY_O;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

    property p_err_pulse;
        PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0000_0000;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("error without ready");

    property p_rdata_idle;
        !PREADY_O |-> PRDATA_O == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");

    property p_set_wins;
        (|events) |=> (sts_q & $past(events)) == $past(events);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event not latched");

    property p_clear;
        wr_done && hit(idx, `LSR_IDX_IRQ_STATUS) |=>
            (sts_q & $past(PWDATA_I[`LSR_EV_WIDTH-1:0] & ~events)) == `LSR_RST_EVENTS;
    endproperty
    a_clear: assert property (p_clear) else $error("status bit not cleared");

    property p_mask_write;
        wr_done && hit(idx, `LSR_IDX_IRQ_MASK) |=> mask_q == $past(PWDATA_I[`LSR_EV_WIDTH-1:0]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask not written");

    c_read_state: cover property (rd_setup && hit(idx, `LSR_IDX_REF_STATE) ##1 PREADY_O);
    c_tune_done:  cover property (syn_q.busy ##1 !syn_q.busy);
    c_irq_clear:  cover property (IRQ_O ##[1:20] !IRQ_O);
    c_unmapped:   cover property (PSLVERR_O);
    c_clear:      cover property (wr_done && hit(idx, `LSR_IDX_IRQ_STATUS));

endmodule

/* File: sim/test_lsr_loop_status.sv */
// Self-checking bench for the loop status bank: field reads, write refusal and interrupts.
// Assumes zero-wait APB answers and status inputs sampled on CLK_I, as handed over.
`timescale 1ns/10ps
`include "lsr_defines.svh"

module test_lsr_loop_status
    import lsr_pkg::*;
;
    logic          clk;
    logic          rst_b;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [11:0]   paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          irq;
    lsr_ref_stat_t rs;
    lsr_syn_stat_t ss;
    int            fail_count = 0;
    int            n_checks   = 0;
    int            cycles     = 0;
    logic [3:0]    sync_codes [6] = '{4'h0, 4'h4, 4'h6, 4'h7, 4'hE, 4'hC};

    lsr_loop_status DUT (
        .CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .REF_STAT_I(rs), .SYN_STAT_I(ss),
        .IRQ_O(irq)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic finish_test();
        $display("Counts: %0d mismatches in %0d checks", fail_count, n_checks);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The whole run needs well under a thousand cycles; this only cuts a hang short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            $display("CHECK FAILED at %0t: timeout", $time);
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, pready}, 32'h1, "ready");
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input logic exp_err);
        logic [31:0] d;
        logic        e;
        apb(1'b0, idx, 32'h0, d, e);
        chk(d, exp, $sformatf("read %h", idx));
        chk({31'h0, e}, {31'h0, exp_err}, $sformatf("read error %h", idx));
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] wd, input logic exp_err);
        logic [31:0] d;
        logic        e;
        apb(1'b1, idx, wd, d, e);
        chk({31'h0, e}, {31'h0, exp_err}, $sformatf("write error %h", idx));
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    task automatic t_reset();
        logic [9:0] idx [13] = '{`LSR_IDX_REF_STATE, `LSR_IDX_DAC_AVG, `LSR_IDX_DAC_CUR,
            `LSR_IDX_REF_FLAGS, `LSR_IDX_EXIT_INFO, `LSR_IDX_RSVD_A, `LSR_IDX_IRQ_STATUS,
            `LSR_IDX_IRQ_MASK, `LSR_IDX_CAP_BANK, `LSR_IDX_ERR_LOW, `LSR_IDX_ERR_HIGH,
            `LSR_IDX_TUNE_SYNC, `LSR_IDX_RSVD_B};
        foreach (idx[i]) rd_chk(idx[i], `LSR_RST_WORD, 1'b0);
        chk({31'h0, irq}, 32'h0, "irq after reset");
    endtask

    task automatic t_ref_fields();
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            rs.state     <= lsr_ref_state_t'(i[2:0]);
            rs.preferred <= 2'h2;
            rs.active    <= 2'h1;
            settle();
            rd_chk(`LSR_IDX_REF_STATE, {25'h0, 2'h2, 2'h1, i[2:0]}, 1'b0);
        end
        @(posedge clk);
        rs.dac_avg    <= 7'h55;
        rs.cmp        <= 1'b1;
        rs.dac_cur    <= 7'h2A;
        rs.active_los <= 1'b1;
        rs.adc_fast   <= 1'b1;
        rs.exit_phase <= 2'h2;
        settle();
        rd_chk(`LSR_IDX_DAC_AVG, 32'h55, 1'b0);
        rd_chk(`LSR_IDX_DAC_CUR, 32'hAA, 1'b0);
        rd_chk(`LSR_IDX_REF_FLAGS, 32'h0A, 1'b0);
        rd_chk(`LSR_IDX_EXIT_INFO, 32'h10, 1'b0);
        rd_chk(`LSR_IDX_RSVD_A, 32'h0, 1'b0);
        @(posedge clk);
        rs.active_los <= 1'b0;
        rs.ref_fast   <= 1'b1;
        rs.adc_fast   <= 1'b0;
        rs.adc_oor    <= 1'b1;
        rs.exit_phase <= 2'h1;
        settle();
        rd_chk(`LSR_IDX_REF_FLAGS, 32'h05, 1'b0);
        rd_chk(`LSR_IDX_EXIT_INFO, 32'h08, 1'b0);
    endtask

    task automatic t_syn_fields();
        @(posedge clk);
        ss.busy    <= 1'b1;
        ss.bank    <= 8'hA5;
        ss.err_neg <= 1'b1;
        ss.err_mag <= 14'h2B6C;
        settle();
        rd_chk(`LSR_IDX_CAP_BANK, 32'h0, 1'b0);
        rd_chk(`LSR_IDX_ERR_LOW, 32'h6C, 1'b0);
        rd_chk(`LSR_IDX_ERR_HIGH, 32'hEB, 1'b0);
        @(posedge clk);
        ss.busy <= 1'b0;
        settle();
        @(posedge clk);
        ss.bank <= 8'h3C;
        settle();
        rd_chk(`LSR_IDX_CAP_BANK, 32'hA5, 1'b0);
        rd_chk(`LSR_IDX_ERR_HIGH, 32'h6B, 1'b0);
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            ss.tune_state <= lsr_tune_state_t'(i[3:0]);
            ss.sync_state <= lsr_sync_state_t'(sync_codes[i % 6]);
            settle();
            rd_chk(`LSR_IDX_TUNE_SYNC, {24'h0, i[3:0], sync_codes[i % 6]}, 1'b0);
        end
    endtask

    task automatic t_refuse();
        wr(`LSR_IDX_REF_STATE, 32'hFFFF_FFFF, 1'b0);
        wr(`LSR_IDX_CAP_BANK, 32'hFFFF_FFFF, 1'b0);
        wr(`LSR_IDX_RSVD_B, 32'hFFFF_FFFF, 1'b0);
        rd_chk(`LSR_IDX_REF_STATE, 32'h4D, 1'b0);
        rd_chk(`LSR_IDX_CAP_BANK, 32'hA5, 1'b0);
        rd_chk(`LSR_IDX_RSVD_B, 32'h0, 1'b0);
        wr(10'h100, 32'hFFFF_FFFF, 1'b1);
        rd_chk(10'h100, 32'h0, 1'b1);
    endtask

    task automatic t_irq();
        wr(`LSR_IDX_IRQ_STATUS, 32'h1F, 1'b0);
        rd_chk(`LSR_IDX_IRQ_STATUS, 32'h0, 1'b0);
        @(posedge clk);
        rs.active_los <= 1'b1;
        rs.state      <= REF_LOCKED;
        settle();
        rd_chk(`LSR_IDX_IRQ_STATUS, 32'h09, 1'b0);
        chk({31'h0, irq}, 32'h0, "irq while masked");
        wr(`LSR_IDX_IRQ_MASK, 32'h01, 1'b0);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1, "irq after unmask");
        rd_chk(`LSR_IDX_IRQ_MASK, 32'h01, 1'b0);
        wr(`LSR_IDX_IRQ_STATUS, 32'h01, 1'b0);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        rd_chk(`LSR_IDX_IRQ_STATUS, 32'h08, 1'b0);
        @(posedge clk);
        rs.state   <= REF_HOLDOVER;
        rs.adc_oor <= 1'b0;
        ss.busy    <= 1'b1;
        @(posedge clk);
        rs.adc_oor <= 1'b1;
        ss.busy    <= 1'b0;
        settle();
        rd_chk(`LSR_IDX_IRQ_STATUS, 32'h1E, 1'b0);
        rd_chk(`LSR_IDX_CAP_BANK, 32'h3C, 1'b0);
    endtask

    initial begin
        rst_b   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        rs      = '0;
        ss      = '0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_ref_fields();
        t_syn_fields();
        t_refuse();
        t_irq();
        finish_test();
    end
endmodule
